// ---- design/ccs_regs.svh ----
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
// register byte offsets
`define CCS_OFS_CMD_STAT 8'h00
`define CCS_OFS_SRC_SEL 8'h04
`define CCS_OFS_SLEEP 8'h08
`define CCS_OFS_STATE 8'h0C
// command/status field positions
`define CCS_CCE_BIT 7
`define CCS_RDY_BIT 4
// selection field positions
`define CCS_CLOCK_OUTPUT_BIT_BIT 6
// sleep control field positions
`define CCS_SE_BIT 0
// change-enable write pattern and reset values
`define CCS_CCE_PATTERN 8'h80
`define CCS_RST_BYTE 8'h00
// change window and wake stall in cycles
`define CCS_CCE_CYC 3'h4
`define CCS_WAKE_STALL_CYC 8'h04
// start-up cycles per start-up code
`define CCS_SUT_CYC0 8'h08
`define CCS_SUT_CYC1 8'h10
`define CCS_SUT_CYC2 8'h20
`define CCS_SUT_CYC3 8'h40
// fuse capture delay after reset release
`define CCS_FUSE_DLY 2'h2
`endif

// ---- design/ccs_pkg.sv ----
package ccs_pkg;
    // clock switch commands
    typedef enum logic [3:0] {
        CCS_CMD_NOP = 4'b0000,
        CCS_CMD_DISABLE = 4'b0001,
        CCS_CMD_ENABLE = 4'b0010,
        CCS_CMD_REQUEST = 4'b0011,
        CCS_CMD_SWITCH = 4'b0100,
        CCS_CMD_RECOVER = 4'b0101,
        CCS_CMD_WDT_AUTO = 4'b0110,
        CCS_CMD_CLKOUT = 4'b0111
    } ccs_cmd_e;
    // sleep mode field codes
    typedef enum logic [1:0] {
        CCS_SM_IDLE = 2'b00,
        CCS_SM_ADCNR = 2'b01,
        CCS_SM_PDOWN = 2'b10,
        CCS_SM_PSAVE = 2'b11
    } ccs_sm_e;
    // power state machine
    typedef enum logic [1:0] {
        CCS_ST_RUN = 2'b00,
        CCS_ST_SLEEP = 2'b01,
        CCS_ST_WAKE = 2'b10
    } ccs_st_e;
    // clock domain and oscillator enables
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_src;
        logic timer_osc;
        logic bod_dis_ok;
    } ccs_gate_s;
    // wake event pins
    typedef struct packed {
        logic [1:0] ext_irq;
        logic pin_change;
        logic spm_ready;
        logic adc_done;
        logic wdt_irq;
        logic usi_start;
        logic timer0_irq;
        logic other_io;
    } ccs_wake_s;
    // everything that crosses in from pins
    typedef struct packed {
        ccs_wake_s wake;
        logic clock_available;
        logic [3:0] active_source;
        logic clock_output_fuse;
        logic [1:0] startup_fuses;
        logic [3:0] source_fuses;
    } ccs_pins_s;
    // command issued to the clock switch
    typedef struct packed {
        logic valid;
        ccs_cmd_e code;
        logic [3:0] source;
        logic [1:0] startup;
    } ccs_cmd_s;
    // complete block state
    typedef struct packed {
        ccs_pins_s s1;
        ccs_pins_s s2;
        logic avail_q;
        logic [1:0] fuse_cnt;
        logic fused;
        logic cce;
        logic [2:0] cce_cnt;
        logic [3:0] cmd_field;
        logic rdy;
        logic clock_output_bit;
        logic [1:0] csut;
        logic [3:0] csel;
        logic se;
        ccs_sm_e sm;
        ccs_sm_e mode;
        ccs_st_e st;
        logic [7:0] wake_cnt;
        logic resume;
        logic wdt_auto;
        logic clkout_en;
        ccs_cmd_s cmd;
        ccs_gate_s gate;
        logic [31:0] rdata;
        logic slverr;
    } ccs_state_s;
endpackage

// ---- design/ccs_clock_sleep.sv ----
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - decode nop, disable, enable, availability request
// - decode source switch and recover source
// - decode watchdog auto reload and clock output
// - selection bit 7 always reads zero
// - clock-out bit resets to inverted fuse
// - recover keeps clock-out and start-up fields
// - start-up field from fuses, used by enable/disable
// - source field from fuses, used by commands
// - recover loads current source into source field
// - idle stops only cpu and flash clocks
// - adc noise mode runs adc, async, oscillators
// - power-down stops all, few wake sources
// - power-save keeps async clock and timer
// - external irqs wake deep modes only level-triggered
// - wake stalls cpu four cycles plus start-up
// - sleep leaves register file and sram intact
// - reset during sleep restarts at reset vector
// - change enable: four-cycle window, no extension
// - ready clears on request/enable, sets when stable
// - sleep mode codes idle, adc, down, save
`include "ccs_regs.svh"
module ccs_clock_sleep
    import ccs_pkg::*;
(
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fuses and clock switch feedback, asynchronous pins
    input wire logic [3:0] source_fuses,
    input wire logic [1:0] startup_fuses,
    input wire logic clock_output_fuse,
    input wire logic clock_available,
    input wire logic [3:0] active_source,
    // wake event pins
    input wire ccs_wake_s wake_events,
    // cpu side, same clock
    input wire logic sleep_instr,
    input wire logic [1:0] ext_irq_level_mode,
    // clock switch command port
    output ccs_cmd_s clock_cmd,
    output logic wdt_auto_reload,
    output logic clock_output_enable,
    // domain gating and wake
    output ccs_gate_s gate_en,
    output logic cpu_resume,
    output logic asleep
);

    ////////////////////////////////////////////////////////////////////
    // state registers
    ccs_state_s q; // current state
    ccs_state_s next_q; // next state
    ccs_pins_s pins_raw; // pins bundled for synchronising
    logic wr_acc; // write access phase
    logic csr_wr; // write hits command/status
    logic [7:0] wbyte; // low write byte
    logic avail_rise; // availability rose
    logic wake_hit; // enabled wake event in current mode
    logic [1:0] ext_ok; // external irq allowed to wake
    logic [7:0] sut_cyc; // start-up cycles for current code

    assign pins_raw = '{wake: wake_events,
                        clock_available: clock_available,
                        active_source: active_source,
                        clock_output_fuse: clock_output_fuse,
                        startup_fuses: startup_fuses,
                        source_fuses: source_fuses};
    assign wr_acc = psel && penable && pwrite;
    assign csr_wr = wr_acc && (paddr == `CCS_OFS_CMD_STAT);
    assign wbyte = pwdata[7:0];
    assign avail_rise = q.s2.clock_available && !q.avail_q;

    ////////////////////////////////////////////////////////////////////
    // gate pattern per power state and mode
    function automatic ccs_gate_s gates_for(ccs_st_e st, ccs_sm_e sm);
        ccs_gate_s g;
        g = '{default: 1'b1};
        g.bod_dis_ok = 1'b0;
        if (st != CCS_ST_RUN) begin
            case (sm)
                // only cpu and flash stop
                CCS_SM_IDLE: begin
                    g.cpu = 1'b0;
                    g.flash = 1'b0;
                end
                // adc, async and oscillators only
                CCS_SM_ADCNR: begin
                    g.cpu = 1'b0;
                    g.flash = 1'b0;
                    g.io = 1'b0;
                end
                // everything stops
                CCS_SM_PDOWN: begin
                    g = '0;
                    g.bod_dis_ok = 1'b1;
                end
                // async clock and timer oscillator stay
                CCS_SM_PSAVE: begin
                    g = '0;
                    g.asy = 1'b1;
                    g.timer_osc = 1'b1;
                    g.bod_dis_ok = 1'b1;
                end
                default: g = '0;
            endcase
            // stalled cpu during wake-up, oscillators restart
            if (st == CCS_ST_WAKE) begin
                g = '{default: 1'b1};
                g.cpu = 1'b0;
                g.flash = 1'b0;
                g.bod_dis_ok = 1'b0;
            end
        end
        return g;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // wake qualification per sleep mode
    always_comb begin
        // idle: any external edge; deep modes need level mode
        ext_ok = (q.mode == CCS_SM_IDLE) ? 2'b11
                                         : ext_irq_level_mode;
        wake_hit = 1'b0;
        case (q.mode)
            // every listed source
            CCS_SM_IDLE: begin
                wake_hit = |q.s2.wake;
            end
            // no other i/o
            CCS_SM_ADCNR: begin
                wake_hit = |(q.s2.wake.ext_irq & ext_ok) ||
                           q.s2.wake.pin_change || q.s2.wake.spm_ready ||
                           q.s2.wake.adc_done || q.s2.wake.wdt_irq ||
                           q.s2.wake.usi_start ||
                           q.s2.wake.timer0_irq;
            end
            // external, pin change, watchdog, serial start only
            CCS_SM_PDOWN: begin
                wake_hit = |(q.s2.wake.ext_irq & ext_ok) ||
                           q.s2.wake.pin_change || q.s2.wake.wdt_irq ||
                           q.s2.wake.usi_start;
            end
            // as power-down plus timer
            CCS_SM_PSAVE: begin
                wake_hit = |(q.s2.wake.ext_irq & ext_ok) ||
                           q.s2.wake.pin_change || q.s2.wake.wdt_irq ||
                           q.s2.wake.usi_start ||
                           q.s2.wake.timer0_irq;
            end
            default: wake_hit = 1'b0;
        endcase
        // start-up cycles from start-up code
        case (q.csut)
            2'b00: sut_cyc = `CCS_SUT_CYC0;
            2'b01: sut_cyc = `CCS_SUT_CYC1;
            2'b10: sut_cyc = `CCS_SUT_CYC2;
            default: sut_cyc = `CCS_SUT_CYC3;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        next_q = q;
        // two-flop synchronisers
        next_q.s1 = pins_raw;
        next_q.s2 = q.s1;
        next_q.avail_q = q.s2.clock_available;
        next_q.cmd.valid = 1'b0;
        next_q.resume = 1'b0;
        // change window countdown
        if (q.cce) begin
            next_q.cce_cnt = q.cce_cnt - 3'h1;
            if (q.cce_cnt == 3'h1) begin
                next_q.cce = 1'b0;
            end
        end
        // register writes
        if (wr_acc) begin
            case (paddr)
                // command/status: protected sequence
                `CCS_OFS_CMD_STAT: begin
                    if (wbyte == `CCS_CCE_PATTERN) begin
                        // open only; a rewrite keeps the window
                        if (!q.cce) begin
                            next_q.cce = 1'b1;
                            next_q.cce_cnt = `CCS_CCE_CYC;
                        end
                    end else if (q.cce && !wbyte[`CCS_CCE_BIT]) begin
                        next_q.cce = 1'b0;
                        next_q.cmd_field = wbyte[3:0];
                        next_q.cmd.valid = !wbyte[3];
                        next_q.cmd.code = ccs_cmd_e'({1'b0, wbyte[2:0]});
                        next_q.cmd.source = q.csel;
                        next_q.cmd.startup = q.csut;
                        case (wbyte[3:0])
                            // availability lost until confirmed
                            CCS_CMD_ENABLE, CCS_CMD_REQUEST: begin
                                next_q.rdy = 1'b0;
                            end
                            // current source into source field
                            CCS_CMD_RECOVER: begin
                                next_q.csel = q.s2.active_source;
                            end
                            // watchdog auto reload
                            CCS_CMD_WDT_AUTO: begin
                                next_q.wdt_auto = 1'b1;
                            end
                            // clock output from selection bit
                            CCS_CMD_CLKOUT: begin
                                next_q.clkout_en = q.clock_output_bit;
                            end
                            // nop, disable, switch: command only
                            default: ;
                        endcase
                    end else begin // ignored outside window
                        next_q.cmd_field = q.cmd_field;
                    end
                end
                // selection register, bit 7 not stored
                `CCS_OFS_SRC_SEL: begin
                    next_q.clock_output_bit = wbyte[`CCS_CLOCK_OUTPUT_BIT_BIT];
                    next_q.csut = wbyte[5:4];
                    next_q.csel = wbyte[3:0];
                end
                // sleep control
                `CCS_OFS_SLEEP: begin
                    next_q.se = wbyte[`CCS_SE_BIT];
                    next_q.sm = ccs_sm_e'(wbyte[2:1]);
                end
                default: ; // read-only or unmapped: dropped
            endcase
        end
        // ready sets on availability, set wins
        if (avail_rise) begin
            next_q.rdy = 1'b1;
        end
        // fuse capture shortly after reset release
        if (!q.fused) begin
            next_q.fuse_cnt = q.fuse_cnt + 2'h1;
            if (q.fuse_cnt == `CCS_FUSE_DLY) begin
                next_q.fused = 1'b1;
                next_q.clock_output_bit = !q.s2.clock_output_fuse;
                next_q.csut = q.s2.startup_fuses;
                next_q.csel = q.s2.source_fuses;
            end
        end
        // power state machine; memories are never touched
        case (q.st)
            // enter sleep on instruction with enable set
            CCS_ST_RUN: begin
                if (sleep_instr && q.se) begin
                    next_q.st = CCS_ST_SLEEP;
                    next_q.mode = q.sm;
                end
            end
            // wait for a qualified wake event
            CCS_ST_SLEEP: begin
                if (wake_hit) begin
                    next_q.st = CCS_ST_WAKE;
                    next_q.wake_cnt = sut_cyc + `CCS_WAKE_STALL_CYC;
                end
            end
            // stall, then resume after sleep instruction
            CCS_ST_WAKE: begin
                next_q.wake_cnt = q.wake_cnt - 8'h01;
                if (q.wake_cnt == 8'h01) begin
                    next_q.st = CCS_ST_RUN;
                    next_q.resume = 1'b1;
                end
            end
            default: next_q.st = CCS_ST_RUN;
        endcase
        next_q.gate = gates_for(next_q.st, next_q.mode);
        // read data captured in setup phase
        next_q.rdata = '0;
        next_q.slverr = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                `CCS_OFS_CMD_STAT: begin
                    next_q.rdata[7:0] = {q.cce, 2'b00, q.rdy,
                                         q.cmd_field};
                end
                `CCS_OFS_SRC_SEL: begin
                    next_q.rdata[7:0] = {1'b0, q.clock_output_bit, q.csut,
                                         q.csel};
                end
                `CCS_OFS_SLEEP: begin
                    next_q.rdata[2:0] = {q.sm, q.se};
                end
                `CCS_OFS_STATE: begin
                    next_q.rdata[9:0] = {q.st, q.gate};
                end
                default: begin
                    next_q.slverr = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register; reset also returns to the reset vector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.gate <= '{default: 1'b1};
            q.gate.bod_dis_ok <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign pready = 1'b1;
    assign prdata = q.rdata;
    assign pslverr = q.slverr && psel && penable;
    assign clock_cmd = q.cmd;
    assign wdt_auto_reload = q.wdt_auto;
    assign clock_output_enable = q.clkout_en;
    assign gate_en = q.gate;
    assign cpu_resume = q.resume;
    assign asleep = (q.st != CCS_ST_RUN);

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // window closes within four cycles of opening, rewrite or not
    sequence cce_opened;
        $rose(q.cce);
    endsequence
    cce_window_a: assert property (cce_opened |->
        ##[1:4] !q.cce)
        else $error("change window not closed after four cycles");

    cmd_ignored_a: assert property (csr_wr && !q.cce &&
        wbyte != `CCS_CCE_PATTERN |=> $stable(q.cmd_field) &&
        !q.cmd.valid)
        else $error("command taken outside window");
    ready_clear_a: assert property (q.cmd.valid &&
        (q.cmd.code == CCS_CMD_ENABLE || q.cmd.code == CCS_CMD_REQUEST)
        && !$past(avail_rise) |-> !q.rdy)
        else $error("ready not cleared by request");

    recover_keep_a: assert property (q.cmd.valid &&
        q.cmd.code == CCS_CMD_RECOVER |-> q.clock_output_bit == $past(q.clock_output_bit) &&
        q.csut == $past(q.csut))
        else $error("recover changed clock-out or start-up");
    recover_load_a: assert property (q.cmd.valid &&
        q.cmd.code == CCS_CMD_RECOVER |->
        q.csel == $past(q.s2.active_source))
        else $error("recover did not load active source");
    clkout_apply_a: assert property (q.cmd.valid &&
        q.cmd.code == CCS_CMD_CLKOUT |->
        clock_output_enable == $past(q.clock_output_bit))
        else $error("clock output not applied");

    idle_gates_a: assert property (q.st == CCS_ST_SLEEP &&
        q.mode == CCS_SM_IDLE |-> !gate_en.cpu && !gate_en.flash &&
        gate_en.io && gate_en.adc && gate_en.asy)
        else $error("idle gating wrong");
    pdown_gates_a: assert property (q.st == CCS_ST_SLEEP &&
        q.mode == CCS_SM_PDOWN |-> gate_en == 8'h01)
        else $error("power-down gating wrong");
    psave_gates_a: assert property (q.st == CCS_ST_SLEEP &&
        q.mode == CCS_SM_PSAVE |-> gate_en.asy && gate_en.timer_osc &&
        !gate_en.main_src && !gate_en.io)
        else $error("power-save gating wrong");

    sequence woke;
        q.st == CCS_ST_SLEEP ##1 q.st == CCS_ST_WAKE;
    endsequence
    wake_stall_a: assert property (woke |-> (!gate_en.cpu &&
        !cpu_resume)[*4])
        else $error("cpu not stalled four cycles on wake");
    sel_reserved_a: assert property (psel && !penable && !pwrite &&
        paddr == `CCS_OFS_SRC_SEL |=> !prdata[7])
        else $error("reserved selection bit read as one");
endmodule

// ---- bench/ccs_clock_sleep_bench.sv ----
`timescale 1ns/1ps
// compare two values, count it, report a mismatch at once
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module ccs_clock_sleep_bench import ccs_pkg::*;;
    ////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic clock_available = 1'b0;
    logic [3:0] active_source = 4'h9; // source reported back on recover
    ccs_wake_s wake_events = '0;
    logic co_fuse = 1'b0; // clock-out fuse pin
    logic sleep_instr = 1'b0;
    logic [1:0] ext_irq_level_mode = 2'b10; // only irq one level-configured
    ccs_cmd_s clock_cmd;
    logic wdt_auto_reload, clock_output_enable, cpu_resume, asleep;
    ccs_gate_s gate_en;
    int n_fail = 0;
    int n_tests = 0;
    int n_cmd = 0; // clock switch command pulses seen
    logic [31:0] rd;
    logic err;
    ////////////////////////////////////////////////////////////////////
    // fuses: source 6, start-up 01, clock-out fuse from co_fuse
    ccs_clock_sleep u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .source_fuses(4'h6), .startup_fuses(2'b01),
        .clock_output_fuse(co_fuse), .clock_available(clock_available),
        .active_source(active_source), .wake_events(wake_events),
        .sleep_instr(sleep_instr), .ext_irq_level_mode(ext_irq_level_mode),
        .clock_cmd(clock_cmd), .wdt_auto_reload(wdt_auto_reload),
        .clock_output_enable(clock_output_enable), .gate_en(gate_en),
        .cpu_resume(cpu_resume), .asleep(asleep));
    // clock, 10 ns period
    initial begin
        forever #5 pclk = ~pclk;
    end
    // count command pulses
    always @(posedge pclk) begin
        if (clock_cmd.valid === 1'b1) begin
            n_cmd <= n_cmd + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // one apb transfer; answer taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // open the change window, then write a command
    task automatic cmd(input logic [7:0] c);
        apb(1'b1, 8'h00, 32'h0000_0080);
        apb(1'b1, 8'h00, {24'h00_0000, c});
    endtask
    // one sleep instruction pulse
    task automatic pulse_sleep;
        @(posedge pclk);
        sleep_instr <= 1'b1;
        @(posedge pclk);
        sleep_instr <= 1'b0;
        @(negedge pclk);
    endtask
    // sleep in mode m, try refused wake, then wake and time the stall
    task automatic nap(input logic [1:0] m, input logic [7:0] g,
            input logic [8:0] w, input logic [8:0] bad);
        int k;
        k = 0;
        apb(1'b1, 8'h08, {29'h0, m, 1'b1});
        pulse_sleep();
        `CHK(gate_en, g)
        @(posedge pclk);
        wake_events <= bad;
        repeat (10) @(negedge pclk);
        `CHK(asleep, 1'b1)
        @(posedge pclk);
        wake_events <= w;
        do begin
            @(posedge pclk);
            k++;
            @(negedge pclk);
        end while (cpu_resume !== 1'b1 && k < 200);
        `CHK(k, 23)
        @(posedge pclk);
        wake_events <= '0;
        repeat (3) @(negedge pclk);
        `CHK({asleep, gate_en}, 9'h0FE)
    endtask
    // verdict
    task automatic end_of_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
    // main sequence
    initial begin
        logic [3:0] e_src;
        int c0;
        e_src = 4'h6;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0000_0056)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        // commands without a proper window are dropped
        apb(1'b1, 8'h00, 32'h0000_0002);
        apb(1'b1, 8'h00, 32'h0000_0081);
        apb(1'b1, 8'h00, 32'h0000_0002);
        apb(1'b0, 8'h00, 32'h0);
        `CHK({n_cmd, rd}, {32'd0, 32'h0})
        // command codes 1 to 7, plus a 1xxx code
        for (int c = 1; c < 9; c++) begin
            c0 = n_cmd;
            cmd(c[7:0]);
            repeat (2) @(negedge pclk);
            `CHK(n_cmd - c0, (c < 8) ? 1 : 0)
            if (c < 8) `CHK(clock_cmd.code, c[3:0])
            if (c < 8 && c != 5) `CHK({clock_cmd.source, clock_cmd.startup},
                {e_src, 2'b01})
            if (c == 5) e_src = 4'h9;
        end
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0000_0059)
        `CHK({wdt_auto_reload, clock_output_enable}, 2'b11)
        // rewriting the enable bit does not extend the window
        apb(1'b1, 8'h00, 32'h0000_0080);
        apb(1'b1, 8'h00, 32'h0000_0080);
        apb(1'b1, 8'h00, 32'h0000_0002);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0000_0008)
        // ready sets on a stable clock, clears on a request
        @(posedge pclk);
        clock_available <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0000_0018)
        cmd(8'h03);
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0000_0003)
        // sleep without the enable bit is ignored
        apb(1'b1, 8'h08, 32'h0);
        pulse_sleep();
        `CHK(asleep, 1'b0)
        nap(2'b00, 8'h3E, 9'h001, 9'h000);
        nap(2'b01, 8'h1E, 9'h010, 9'h001);
        nap(2'b10, 8'h01, 9'h008, 9'h081);
        nap(2'b11, 8'h0B, 9'h100, 9'h081);
        // reserved selection bit reads zero
        apb(1'b1, 8'h04, 32'h0000_00FF);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0000_007F)
        // reset while asleep returns to run
        apb(1'b1, 8'h08, 32'h0000_0005);
        pulse_sleep();
        @(posedge pclk);
        presetn <= 1'b0;
        co_fuse <= 1'b1;
        repeat (2) @(negedge pclk);
        `CHK({asleep, gate_en}, 9'h0FE)
        // second release: inverted fuse reaches the clock-out bit
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h0000_0016)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK(rd, 32'h0000_00FE)
        end_of_test();
    end
endmodule
